// ---- inc/lvd_pkg.sv ----
package lvd_pkg;

    // Bus geometry
    localparam int WB_AW = 8;
    localparam int WB_DW = 32;

    // Register byte addresses
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] LEVEL_OFS  = 8'h04;
    localparam logic [7:0] IRQF_OFS   = 8'h08;
    localparam logic [7:0] MASK_OFS   = 8'h0C;
    localparam logic [7:0] CAUSE_OFS  = 8'h10;
    localparam logic [7:0] SETTLE_OFS = 8'h14;

    // Control register field positions
    localparam int CTRL_FLAG_BIT  = 0;
    localparam int CTRL_MODE_BIT  = 1;
    localparam int CTRL_SPARE_BIT = 4;
    localparam int CTRL_EN_BIT    = 7;

    // Single-bit fields of the other registers, and the width of the level field
    localparam int IRQF_REQ_BIT   = 0;
    localparam int MASK_BIT       = 0;
    localparam int CAUSE_LV_BIT   = 0;
    localparam int SETTLE_BIT     = 0;
    localparam int LEVEL_W        = 4;

    // Values after reset
    localparam logic [LEVEL_W-1:0] LEVEL_RST = 4'h0;
    localparam logic               MASK_RST  = 1'b1;

    // Comparator settle time
    localparam int CLK_FREQ_HZ    = 10_000_000;
    localparam int SETTLE_TIME_US = 200;
    localparam int SETTLE_CYC_I   = (SETTLE_TIME_US * (CLK_FREQ_HZ / 1_000_000) < 1) ? 1 :
                                    SETTLE_TIME_US * (CLK_FREQ_HZ / 1_000_000);
    localparam int SETTLE_W       = 12;
    localparam logic [SETTLE_W-1:0] SETTLE_CYC = SETTLE_CYC_I[SETTLE_W-1:0];

    // Places a byte in the low lane of a bus word
    function automatic logic [WB_DW-1:0] byte_word(input logic [7:0] b);
        return {24'h000000, b};
    endfunction : byte_word

endpackage : lvd_pkg

// ---- src/lvd_sync.sv ----
`timescale 1ns/10ps
module lvd_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_reg;

    // Two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : lvd_sync

// ---- src/lvd_wb_slave.sv ----
`timescale 1ns/10ps
module lvd_wb_slave
    import lvd_pkg::*;
(
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [WB_DW-1:0] rd_data,
    output logic                  wb_ack_o,
    output logic      [WB_DW-1:0] wb_dat_o,
    output logic                  wr_en
);

    logic req;

    // New request: strobe seen and not yet answered
    assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // Write lands at the edge where the master samples ack
    assign wr_en = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];

    // Ack one cycle after the request, dropped in the next
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // Read data captured with the request
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wb_dat_o <= '0;
        end else if (req) begin
            wb_dat_o <= wb_we_i ? '0 : rd_data;
        end
    end

endmodule : lvd_wb_slave

// ---- src/lvd_ctrl.sv ----
// Behaviour
// (R1) Reset mode: internal reset asserted while supply is below level.
// (R2) Interrupt mode: interrupt request raised while supply is below level.
// (R3) Software masks, selects level, enables, waits, checks flag, then sets reset mode.
// (R4) Unmasked interrupt may fire right after enable; software must mask first.
// (R5) Setting reset mode with supply above level gives no reset.
// (R6) Reset mode stops by writing zero, or clearing mode then enable.
// (R7) Interrupt mode stops by writing zero, or clearing enable alone.
// (R8) External reset sets the interrupt mask to one.
// (R9) Interrupt start: same first steps, clear request, unmask, enable globally.
// (R10) Low-voltage reset cause lives in bit 0 of the cause register.
// (R11) Software picks level with four low bits of level register before enable.
// (R12) Supply hovering near level may reset repeatedly; logic tolerates that.
// (R13) Software waits out supply fluctuation with a timer after reset.
// (R14) Handler checks flag, clears request bit 0, re-enables interrupts.
// (R15) Long fluctuation: software waits and checks flag before enabling interrupts.
// (R16) Interrupt request equals flag only while enabled and in interrupt mode.
// (R17) Enable and mode bits cleared by every reset except the low-voltage one.
// (R18) Low-voltage reset sets the reset cause flag.
// (R19) Comparator output passes two flip-flops before any use.
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
module lvd_ctrl
    import lvd_pkg::*;
(
    input  wire logic               clk_sys,
    input  wire logic               resetn,
    input  wire logic               sys_reset_req,
    input  wire logic               below_level_async,
    output logic                    comp_enable,
    output logic      [LEVEL_W-1:0] level_code,
    output logic                    lv_reset,
    output logic                    irq,
    input  wire logic [WB_AW-1:0]   wb_adr_i,
    input  wire logic [WB_DW-1:0]   wb_dat_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic               wb_we_i,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    output logic      [WB_DW-1:0]   wb_dat_o,
    output logic                    wb_ack_o
);

    // Register state
    logic                 enable_reg;
    logic                 mode_reg;
    logic                 spare_reg;
    logic [LEVEL_W-1:0]   level_reg;
    logic                 mask_reg;
    logic                 irq_req_reg;
    logic                 cause_reg;
    logic                 src_prev_reg;
    logic                 lv_reset_reg;
    logic                 irq_reg;
    logic [SETTLE_W-1:0]  settle_cnt_reg;

    // Next values
    logic                 enable_next;
    logic                 mode_next;
    logic                 spare_next;
    logic [LEVEL_W-1:0]   level_next;
    logic                 mask_next;
    logic                 irq_req_next;
    logic                 cause_next;
    logic [SETTLE_W-1:0]  settle_cnt_next;

    // Datapath wires
    logic                 below_sync;
    logic                 flag;
    logic                 irq_src;
    logic                 irq_rise;
    logic                 reset_cond;
    logic                 settled;
    logic                 wr_en;
    logic                 wr_ok;
    logic [7:0]           wbyte;
    logic [WB_DW-1:0]     rd_data;
    logic                 ctl_clear;
    logic                 irq_next;
    logic                 lv_reset_next;

    // Read word of each register
    logic [WB_DW-1:0]     ctrl_rd;
    logic [WB_DW-1:0]     level_rd;
    logic [WB_DW-1:0]     irqf_rd;
    logic [WB_DW-1:0]     mask_rd;
    logic [WB_DW-1:0]     cause_rd;
    logic [WB_DW-1:0]     settle_rd;

    // Address decode
    logic                 hit_ctrl;
    logic                 hit_level;
    logic                 hit_irqf;
    logic                 hit_mask;
    logic                 hit_cause;
    logic                 hit_settle;

    // Write strobes per register
    logic                 wr_ctrl;
    logic                 wr_level;
    logic                 wr_irqf;
    logic                 wr_mask;
    logic                 wr_cause;

    // Register bit after a possible software write
    function automatic logic bit_wr(input logic wr, input logic new_v, input logic cur);
        return wr ? new_v : cur;
    endfunction : bit_wr

    // Next value of a sticky bit: a set event wins over a write-one clear
    function automatic logic sticky_next(input logic set_ev, input logic cur, input logic clr);
        return set_ev | (cur & ~clr);
    endfunction : sticky_next

    // Comparator result brought onto clk_sys
    lvd_sync #(
        .W        (1)
    ) u_sync (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .async_in (below_level_async),  // [R19]
        .sync_out (below_sync)
    );

    // Bus slave: ack timing and read capture
    lvd_wb_slave u_wb (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_sel_i (wb_sel_i),
        .rd_data  (rd_data),
        .wb_ack_o (wb_ack_o),
        .wb_dat_o (wb_dat_o),
        .wr_en    (wr_en)
    );

    // Detection flag reads zero while the detector is off
    assign flag       = below_sync & enable_reg;             // [R19]

    // Reset request only in reset mode and below level
    assign reset_cond = flag & mode_reg;                     // [R1] [R5]

    // Interrupt source follows flag only in interrupt mode
    assign irq_src    = flag & ~mode_reg;                    // [R16] [R2]
    assign irq_rise   = irq_src & ~src_prev_reg;             // [R4]

    // Comparator has had its settle time since enable
    assign settled    = (settle_cnt_reg == SETTLE_CYC);

    // Address decode; unmapped addresses hit nothing
    always_comb begin
        hit_ctrl   = 1'b0;
        hit_level  = 1'b0;
        hit_irqf   = 1'b0;
        hit_mask   = 1'b0;
        hit_cause  = 1'b0;
        hit_settle = 1'b0;
        if (wb_adr_i == CTRL_OFS) begin
            hit_ctrl = 1'b1;
        end else if (wb_adr_i == LEVEL_OFS) begin
            hit_level = 1'b1;
        end else if (wb_adr_i == IRQF_OFS) begin
            hit_irqf = 1'b1;
        end else if (wb_adr_i == MASK_OFS) begin
            hit_mask = 1'b1;
        end else if (wb_adr_i == CAUSE_OFS) begin
            hit_cause = 1'b1;
        end else if (wb_adr_i == SETTLE_OFS) begin
            hit_settle = 1'b1;
        end
    end

    // Writes are dropped while the chip sits in low-voltage reset
    assign wr_ok      = wr_en & ~lv_reset_reg;
    assign wbyte      = wb_dat_i[7:0];
    assign wr_ctrl    = wr_ok & hit_ctrl;
    assign wr_level   = wr_ok & hit_level;
    assign wr_irqf    = wr_ok & hit_irqf;
    assign wr_mask    = wr_ok & hit_mask;
    assign wr_cause   = wr_ok & hit_cause;

    // Read words; bits 31:8 read zero
    assign ctrl_rd   = byte_word({enable_reg, 2'b00, spare_reg, 2'b00, mode_reg, flag});
    assign level_rd  = byte_word({4'h0, level_reg});
    assign irqf_rd   = byte_word({7'h00, irq_req_reg});
    assign mask_rd   = byte_word({7'h00, mask_reg});
    assign cause_rd  = byte_word({7'h00, cause_reg});   // [R10]
    assign settle_rd = byte_word({7'h00, settled});

    // Read select; unmapped addresses read zero
    always_comb begin
        rd_data = '0;
        if (hit_ctrl) begin
            rd_data = ctrl_rd;
        end else if (hit_level) begin
            rd_data = level_rd;
        end else if (hit_irqf) begin
            rd_data = irqf_rd;
        end else if (hit_mask) begin
            rd_data = mask_rd;
        end else if (hit_cause) begin
            rd_data = cause_rd;
        end else if (hit_settle) begin
            rd_data = settle_rd;
        end
    end

    // Control bits: whole-byte writes can clear mode and enable together
    assign enable_next = bit_wr(wr_ctrl, wbyte[CTRL_EN_BIT], enable_reg);     // [R6] [R7]
    assign mode_next   = bit_wr(wr_ctrl, wbyte[CTRL_MODE_BIT], mode_reg);     // [R6]
    assign spare_next  = bit_wr(wr_ctrl, wbyte[CTRL_SPARE_BIT], spare_reg);

    // Level code: only the four low bits are kept
    assign level_next  = wr_level ? wbyte[LEVEL_W-1:0] : level_reg;

    // Mask written by software
    assign mask_next   = bit_wr(wr_mask, wbyte[MASK_BIT], mask_reg);

    // Sticky request: a new event wins over a write-one clear
    assign irq_req_next = sticky_next(irq_rise, irq_req_reg,
                                      wr_irqf & wbyte[IRQF_REQ_BIT]);

    // Cause flag: set while low-voltage reset is active, set wins over clear
    assign cause_next  = sticky_next(reset_cond | lv_reset_reg, cause_reg,
                                     wr_cause & wbyte[CAUSE_LV_BIT]);

    // Interrupt logic is cleared by every reset, the low-voltage one included
    assign ctl_clear   = sys_reset_req | lv_reset_reg;

    // Interrupt output: unmasked request, quiet during any reset
    assign irq_next    = irq_req_next & ~mask_next & ~ctl_clear;          // [R4]

    // Internal reset request each cycle; repeats freely while supply hovers
    assign lv_reset_next = reset_cond;                                    // [R1] [R12]

    // Settle counter runs from enable and saturates
    assign settle_cnt_next = !enable_reg ? '0 :
                             settled     ? settle_cnt_reg :
                             settle_cnt_reg + 1'b1;

    // Enable and mode survive the low-voltage reset only
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            enable_reg <= 1'b0;
            mode_reg   <= 1'b0;
            spare_reg  <= 1'b0;
        end else if (sys_reset_req) begin
            enable_reg <= 1'b0;                  // [R17]
            mode_reg   <= 1'b0;                  // [R17]
            spare_reg  <= 1'b0;
        end else begin
            enable_reg <= enable_next;
            mode_reg   <= mode_next;
            spare_reg  <= spare_next;
        end
    end

    // Level code, kept across low-voltage reset
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            level_reg <= LEVEL_RST;
        end else if (sys_reset_req) begin
            level_reg <= LEVEL_RST;
        end else begin
            level_reg <= level_next;
        end
    end

    // Interrupt mask: every reset forces it on
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mask_reg <= MASK_RST;                // [R8]
        end else if (ctl_clear) begin
            mask_reg <= MASK_RST;                // [R8]
        end else begin
            mask_reg <= mask_next;
        end
    end

    // Interrupt request flag
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irq_req_reg  <= 1'b0;
            src_prev_reg <= 1'b0;
        end else if (ctl_clear) begin
            irq_req_reg  <= 1'b0;
            src_prev_reg <= 1'b0;
        end else begin
            irq_req_reg  <= irq_req_next;        // [R2]
            src_prev_reg <= irq_src;
        end
    end

    // Reset cause, cleared only by external reset or software
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cause_reg <= 1'b0;
        end else begin
            cause_reg <= cause_next;             // [R18]
        end
    end

    // Internal reset follows the comparator each cycle, so repeated
    // entry and release needs no extra state
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lv_reset_reg <= 1'b0;
        end else if (sys_reset_req) begin
            lv_reset_reg <= 1'b0;
        end else begin
            lv_reset_reg <= lv_reset_next;       // [R1] [R12]
        end
    end

    // Interrupt output: unmasked request
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;                 // [R4]
        end
    end

    // Settle counter
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            settle_cnt_reg <= '0;
        end else if (sys_reset_req) begin
            settle_cnt_reg <= '0;
        end else begin
            settle_cnt_reg <= settle_cnt_next;
        end
    end

    // Outputs to comparator and system
    assign comp_enable = enable_reg;
    assign level_code  = level_reg;
    assign lv_reset    = lv_reset_reg;
    assign irq         = irq_reg;

endmodule : lvd_ctrl

// ---- test/lvd_ctrl_properties.sv ----
`timescale 1ns/10ps
module lvd_ctrl_properties
    import lvd_pkg::*;
(
    input wire logic               clk_sys,
    input wire logic               resetn,
    input wire logic               sys_reset_req,
    input wire logic               below_level_async,
    input wire logic               comp_enable,
    input wire logic [LEVEL_W-1:0] level_code,
    input wire logic               lv_reset,
    input wire logic               irq,
    input wire logic               wb_we_i,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_ack_o
);
    // A write cycle on the bus
    wire logic wr_req;
    assign wr_req = wb_cyc_i & wb_stb_i & wb_we_i;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    // Bus handshake
    ack_single_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    // Low-voltage reset against comparator, enable and interrupt
    lv_needs_enable_a: assert property (lv_reset |-> comp_enable || $past(wr_req))
        else $error("reset active with detector disabled");
    lv_rise_sync_a: assert property ($rose(lv_reset) |-> $past(below_level_async, 3))
        else $error("reset rose without synchronised comparator");
    lv_release_a: assert property ($fell(below_level_async) ##1 !below_level_async [*2] |=> !lv_reset)
        else $error("reset not released after supply recovered");
    lv_quiets_irq_a: assert property (lv_reset |=> !irq)
        else $error("interrupt during low-voltage reset");
    // Other resets and register stability
    sys_reset_clears_a: assert property (sys_reset_req |=> !comp_enable && !lv_reset && !irq && level_code == 4'h0)
        else $error("other reset left state behind");
    level_hold_a: assert property (!wr_req && !sys_reset_req |=> $stable(level_code))
        else $error("level changed without a write");
    enable_hold_a: assert property (!wr_req && !sys_reset_req |=> $stable(comp_enable))
        else $error("enable changed without a write");
endmodule : lvd_ctrl_properties

bind lvd_ctrl lvd_ctrl_properties u_props (.clk_sys, .resetn, .sys_reset_req, .below_level_async,
    .comp_enable, .level_code, .lv_reset, .irq, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

// ---- test/lvd_supply_model.sv ----
`timescale 1ns/10ps
module lvd_supply_model
    import lvd_pkg::*;
(
    input  wire logic               comp_enable,
    input  wire logic [LEVEL_W-1:0] level_code,
    input  wire logic [LEVEL_W-1:0] supply_step,
    output logic                    below_level_async
);
    // Supply in level steps, higher is lower; output idle low while disabled
    assign below_level_async = comp_enable && (supply_step > level_code);
endmodule : lvd_supply_model

// ---- test/tb_low_voltage_detect_control.sv ----
`timescale 1ns/10ps
module tb_low_voltage_detect_control
    import lvd_pkg::*;
;
    logic               clk_sys = 1'b0;
    logic               resetn = 1'b0;
    logic               sys_reset_req = 1'b0;
    logic [LEVEL_W-1:0] supply_step = 4'h0;
    logic [WB_AW-1:0]   adr = 8'h00;
    logic [WB_DW-1:0]   dat_w = 32'h0;
    logic [3:0]         sel = 4'hF;
    logic               we = 1'b0;
    logic               cyc = 1'b0;
    logic               stb = 1'b0;
    logic [WB_DW-1:0]   dat_r;
    logic [WB_DW-1:0]   rd;
    logic               below;
    logic               comp_en;
    logic               lv_reset;
    logic               irq;
    logic               ack;
    logic [LEVEL_W-1:0] level;
    int                 fail_count = 0;
    int                 samples_checked = 0;

    always #50 clk_sys = ~clk_sys;

    lvd_ctrl dut_u (.clk_sys, .resetn, .sys_reset_req, .below_level_async(below), .comp_enable(comp_en),
        .level_code(level), .lv_reset, .irq, .wb_adr_i(adr), .wb_dat_i(dat_w), .wb_sel_i(sel),
        .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_r), .wb_ack_o(ack));
    lvd_supply_model sup_u (.comp_enable(comp_en), .level_code(level), .supply_step,
        .below_level_async(below));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // One classic bus cycle, released after ack is sampled or after 20 cycles without it
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        adr <= a;
        we <= w;
        dat_w <= d;
        cyc <= 1'b1;
        stb <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) fail_count++;
        rd = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : xfer

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        chk(rd, e);
    endtask : rchk

    // Poll the settled flag; it must not come early
    task automatic settle();
        int n;
        n = 0;
        rd = 32'h0;
        while (rd[0] !== 1'b1 && n < 1000) begin
            xfer(SETTLE_OFS, 1'b0, 32'h0);
            n++;
        end
        chk(rd, 32'h1);
        chk(32'(n > 600 && n < 700), 32'h1);
    endtask : settle

    task automatic end_of_test();
        $display("checks %0d errors %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    // Main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        rchk(CTRL_OFS, 32'h0);
        rchk(MASK_OFS, 32'h1);
        rchk(CAUSE_OFS, 32'h0);
        rchk(8'h1C, 32'h0);
        xfer(CTRL_OFS, 1'b1, 32'h10);
        rchk(CTRL_OFS, 32'h10);
        xfer(CTRL_OFS, 1'b1, 32'h0);
        xfer(MASK_OFS, 1'b1, 32'h1);
        xfer(LEVEL_OFS, 1'b1, 32'h5);
        rchk(LEVEL_OFS, 32'h5);
        chk(32'(level), 32'h5);
        sel <= 4'hE;
        xfer(LEVEL_OFS, 1'b1, 32'hA);
        sel <= 4'hF;
        rchk(LEVEL_OFS, 32'h5);
        xfer(CTRL_OFS, 1'b1, 32'h80);
        settle();
        chk(32'(comp_en), 32'h1);
        rchk(CTRL_OFS, 32'h80);
        xfer(IRQF_OFS, 1'b1, 32'h1);
        xfer(MASK_OFS, 1'b1, 32'h0);
        supply_step <= 4'h9;
        repeat (6) @(posedge clk_sys);
        chk(32'(irq), 32'h1);
        chk(32'(lv_reset), 32'h0);
        rchk(CTRL_OFS, 32'h81);
        supply_step <= 4'h5;
        rchk(IRQF_OFS, 32'h1);
        rchk(CTRL_OFS, 32'h80);
        xfer(IRQF_OFS, 1'b1, 32'h1);
        repeat (6) @(posedge clk_sys);
        chk(32'(irq), 32'h0);
        xfer(MASK_OFS, 1'b1, 32'h1);
        supply_step <= 4'h9;
        repeat (6) @(posedge clk_sys);
        chk(32'(irq), 32'h0);
        rchk(IRQF_OFS, 32'h1);
        supply_step <= 4'h0;
        xfer(CTRL_OFS, 1'b1, 32'h0);
        rchk(CTRL_OFS, 32'h0);
        // Reset mode with two sags in a row
        xfer(CTRL_OFS, 1'b1, 32'h80);
        settle();
        xfer(CTRL_OFS, 1'b1, 32'h82);
        repeat (6) @(posedge clk_sys);
        chk(32'(lv_reset), 32'h0);
        for (int i = 0; i < 2; i++) begin
            supply_step <= 4'hF;
            repeat (5) @(posedge clk_sys);
            chk(32'(lv_reset), 32'h1);
            xfer(CTRL_OFS, 1'b1, 32'h0);
            rchk(CTRL_OFS, 32'h83);
            rchk(CAUSE_OFS, 32'h1);
            supply_step <= 4'h0;
            repeat (5) @(posedge clk_sys);
            chk(32'(lv_reset), 32'h0);
        end
        repeat (50) @(posedge clk_sys);
        chk(32'(lv_reset), 32'h0);
        xfer(CAUSE_OFS, 1'b1, 32'h1);
        rchk(CAUSE_OFS, 32'h0);
        xfer(CTRL_OFS, 1'b1, 32'h80);
        rchk(CTRL_OFS, 32'h80);
        xfer(CTRL_OFS, 1'b1, 32'h0);
        // Other reset, then external reset in mid-run
        xfer(CTRL_OFS, 1'b1, 32'h82);
        xfer(MASK_OFS, 1'b1, 32'h0);
        sys_reset_req <= 1'b1;
        @(posedge clk_sys);
        sys_reset_req <= 1'b0;
        rchk(CTRL_OFS, 32'h0);
        rchk(LEVEL_OFS, 32'h0);
        xfer(MASK_OFS, 1'b1, 32'h0);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        rchk(MASK_OFS, 32'h1);
        end_of_test();
    end

    // Watchdog
    initial begin
        repeat (30000) @(posedge clk_sys);
        fail_count++;
        end_of_test();
    end
endmodule : tb_low_voltage_detect_control
